// ### verilog/sbit_timer.sv
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module sbit_timer
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // device and pin inputs
    input  wire logic        external_count_input,
    input  wire logic        idle_mode,
    // timer event
    output logic             timer_flag
);
    logic [15:0]   timer_control;
    logic [15:0]   count_value_register;
    logic [15:0]   period_value;
    logic          flag;
    logic [15:0]   next_timer_control;
    logic [15:0]   next_count_value_register;
    logic [15:0]   next_period_value;
    logic          next_flag;
    logic          pin_meta;
    logic          pin_sync;
    logic          pin_prev;
    logic          idle_meta;
    logic          idle_sync;
    logic          async_stage;
    logic          next_async_stage;
    logic          aw_held;
    logic          w_held;
    logic [3:0]    aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          next_aw_held;
    logic          next_w_held;
    logic [3:0]    next_aw_addr;
    logic [31:0]   next_w_data;
    logic [3:0]    next_w_strb;
    logic          next_bvalid;
    logic [1:0]    next_bresp;
    logic          next_rvalid;
    logic [31:0]   next_rdata;
    logic [1:0]    next_rresp;
    logic          running;
    logic          pin_rise;
    logic          raw_tick;
    logic          pre_tick;
    logic          count_tick;
    logic          gate_ok;
    logic          do_write;
    logic          sync_locked;
    sbit_pkg::sbit_mode_type mode;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
        merge16 = old;
        if (strb[0])
            merge16[7:0] = data[7:0];
        if (strb[1])
            merge16[15:8] = data[15:8];
    endfunction

    function automatic logic addr_known(input logic [3:0] addr);
        addr_known = (addr == sbit_pkg::off_control) || (addr == sbit_pkg::off_count) ||
                     (addr == sbit_pkg::off_period) || (addr == sbit_pkg::off_status);
    endfunction

    // mode decode
    always_comb
    begin
        if (!timer_control[sbit_pkg::source_bit])
            mode = timer_control[sbit_pkg::gate_bit] ? sbit_pkg::sbit_mode_gated
                                                    : sbit_pkg::sbit_mode_timer;
        else
            mode = timer_control[sbit_pkg::sync_bit] ? sbit_pkg::sbit_mode_sync
                                                    : sbit_pkg::sbit_mode_async;
    end

    // pin edge and idle level, two flip-flops before use
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_meta  <= 1'b0;
            pin_sync  <= 1'b0;
            pin_prev  <= 1'b0;
            idle_meta <= 1'b0;
            idle_sync <= 1'b0;
        end
        else
        begin
            pin_meta  <= external_count_input;
            pin_sync  <= pin_meta;
            pin_prev  <= pin_sync;
            idle_meta <= idle_mode;
            idle_sync <= idle_meta;
        end
    end

    assign pin_rise = pin_sync && !pin_prev;
    assign running  = timer_control[sbit_pkg::run_bit] &&
                      !(timer_control[sbit_pkg::idle_halt_bit] && idle_sync);
    // aclk stands for the instruction clock; each aclk cycle is one count edge
    always_comb
    begin
        case (mode)
            sbit_pkg::sbit_mode_timer: raw_tick = running;
            sbit_pkg::sbit_mode_gated: raw_tick = running;
            sbit_pkg::sbit_mode_sync:  raw_tick = running && pin_rise;
            sbit_pkg::sbit_mode_async: raw_tick = running && pin_rise;
            default:                   raw_tick = 1'b0;
        endcase
    end
    assign gate_ok = (mode != sbit_pkg::sbit_mode_gated) || pin_sync;

    sbit_prescaler u_prescaler
    (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .tick_in         (raw_tick && gate_ok),
        .prescale_select (timer_control[sbit_pkg::prescale_lo +: 2]),
        .clear           (!running),
        .tick_out        (pre_tick)
    );

    // synchronous mode re-times the prescaled event; asynchronous mode uses it directly
    always_comb
    begin
        next_async_stage = pre_tick;
        if (mode == sbit_pkg::sbit_mode_sync)
            count_tick = async_stage;
        else
            count_tick = pre_tick;
    end

    assign sync_locked = (mode == sbit_pkg::sbit_mode_sync) && timer_control[sbit_pkg::run_bit];
    assign do_write    = aw_held && w_held && (!s_axi_bvalid || s_axi_bready);

    // bus write channel and registers
    always_comb
    begin
        next_aw_held              = aw_held;
        next_w_held               = w_held;
        next_aw_addr              = aw_addr;
        next_w_data               = w_data;
        next_w_strb               = w_strb;
        next_bvalid               = s_axi_bvalid && !s_axi_bready;
        next_bresp                = s_axi_bresp;
        next_timer_control        = timer_control;
        next_count_value_register = count_value_register;
        next_period_value         = period_value;
        next_flag                 = flag;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write)
        begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = addr_known(aw_addr) ? sbit_pkg::resp_okay : sbit_pkg::resp_slverr;
            case (aw_addr)
                sbit_pkg::off_control:
                    next_timer_control = merge16(timer_control, w_data, w_strb) & sbit_pkg::control_mask;
                sbit_pkg::off_count:
                    if (!sync_locked)
                        next_count_value_register = merge16(count_value_register, w_data, w_strb);
                sbit_pkg::off_period:
                    next_period_value = merge16(period_value, w_data, w_strb);
                sbit_pkg::off_status:
                    if (w_strb[0] && w_data[sbit_pkg::flag_bit])
                        next_flag = 1'b0;
                default:
                    next_period_value = period_value;
            endcase
        end
        // counting follows the write so an event beats a same-cycle flag clear
        if (count_tick)
        begin
            if (count_value_register == period_value)
            begin
                next_count_value_register = 16'h0000;
                next_flag                 = 1'b1;
            end
            else
            begin
                next_count_value_register = count_value_register + 16'h0001;
            end
        end
    end

    // bus read channel
    always_comb
    begin
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp  = addr_known(s_axi_araddr) ? sbit_pkg::resp_okay : sbit_pkg::resp_slverr;
            case (s_axi_araddr)
                sbit_pkg::off_control: next_rdata = {16'h0000, timer_control};
                sbit_pkg::off_count:   next_rdata = {16'h0000, count_value_register};
                sbit_pkg::off_period:  next_rdata = {16'h0000, period_value};
                sbit_pkg::off_status:  next_rdata = {30'h0, idle_sync, flag};
                default:               next_rdata = 32'h00000000;
            endcase
        end
    end

    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;
    assign s_axi_arready = !s_axi_rvalid;
    assign timer_flag    = flag;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timer_control        <= sbit_pkg::control_reset;
            count_value_register <= sbit_pkg::count_reset;
            period_value         <= sbit_pkg::period_reset;
            flag                 <= 1'b0;
            async_stage          <= 1'b0;
            aw_held              <= 1'b0;
            w_held               <= 1'b0;
            aw_addr              <= 4'h0;
            w_data               <= 32'h00000000;
            w_strb               <= 4'h0;
            s_axi_bvalid         <= 1'b0;
            s_axi_bresp          <= sbit_pkg::resp_okay;
            s_axi_rvalid         <= 1'b0;
            s_axi_rdata          <= 32'h00000000;
            s_axi_rresp          <= sbit_pkg::resp_okay;
        end
        else
        begin
            timer_control        <= next_timer_control;
            count_value_register <= next_count_value_register;
            period_value         <= next_period_value;
            flag                 <= next_flag;
            async_stage          <= next_async_stage;
            aw_held              <= next_aw_held;
            w_held               <= next_w_held;
            aw_addr              <= next_aw_addr;
            w_data               <= next_w_data;
            w_strb               <= next_w_strb;
            s_axi_bvalid         <= next_bvalid;
            s_axi_bresp          <= next_bresp;
            s_axi_rvalid         <= next_rvalid;
            s_axi_rdata          <= next_rdata;
            s_axi_rresp          <= next_rresp;
        end
    end
endmodule // sbit_timer

// ### common/sbit_pkg.sv
package sbit_pkg;
    // register byte offsets
    localparam logic [3:0] off_control = 4'h0;
    localparam logic [3:0] off_count   = 4'h4;
    localparam logic [3:0] off_period  = 4'h8;
    localparam logic [3:0] off_status  = 4'hc;

    // control field positions
    localparam int run_bit       = 15;
    localparam int idle_halt_bit = 13;
    localparam int gate_bit      = 6;
    localparam int prescale_lo   = 4;
    localparam int sync_bit      = 2;
    localparam int source_bit    = 1;

    // status field positions
    localparam int flag_bit      = 0;
    localparam int idle_bit      = 1;

    // writable control bits; the rest read as zero
    localparam logic [15:0] control_mask  = 16'ha076;
    localparam logic [15:0] control_reset = 16'h0000;
    localparam logic [15:0] count_reset   = 16'h0000;
    localparam logic [15:0] period_reset  = 16'hffff;

    // prescale terminal counts for 1:1, 1:8, 1:64, 1:256
    localparam logic [7:0] div1_last   = 8'h00;
    localparam logic [7:0] div8_last   = 8'h07;
    localparam logic [7:0] div64_last  = 8'h3f;
    localparam logic [7:0] div256_last = 8'hff;

    localparam logic [1:0] resp_okay   = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;

    typedef enum logic [3:0]
    {
        sbit_mode_timer = 4'b0001,
        sbit_mode_gated = 4'b0010,
        sbit_mode_sync  = 4'b0100,
        sbit_mode_async = 4'b1000
    } sbit_mode_type;
endpackage

// ### verilog/sbit_prescaler.sv
`timescale 1ns/1ps
module sbit_prescaler
(
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // control
    input  wire logic       tick_in,
    input  wire logic [1:0] prescale_select,
    input  wire logic       clear,
    // prescaled event
    output logic            tick_out
);
    logic [7:0] div_count;
    logic [7:0] next_div_count;
    logic [7:0] last_value;

    always_comb
    begin
        case (prescale_select)
            2'b00:   last_value = sbit_pkg::div1_last;
            2'b01:   last_value = sbit_pkg::div8_last;
            2'b10:   last_value = sbit_pkg::div64_last;
            default: last_value = sbit_pkg::div256_last;
        endcase
        next_div_count = div_count;
        tick_out       = 1'b0;
        if (clear)
        begin
            next_div_count = 8'h00;
        end
        else if (tick_in)
        begin
            if (div_count >= last_value)
            begin
                next_div_count = 8'h00;
                tick_out       = 1'b1;
            end
            else
            begin
                next_div_count = div_count + 8'h01;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            div_count <= 8'h00;
        else
            div_count <= next_div_count;
    end
endmodule // sbit_prescaler

// ### verification/sbit_chk.sv
`timescale 1ns/1ps
module sbit_chk
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // bus handshakes
    input  wire logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    input  wire logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // timer event
    input  wire logic        timer_flag
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_aw_held: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("aw ready stayed up");
    a_w_held: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready) else $error("w ready stayed up");
    a_b_timely: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_b_cause: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
        else $error("response without request");
    a_r_timely: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_r_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read data repeated");
    a_flag_clear: assert property ($fell(timer_flag) |-> $past(s_axi_wvalid, 2))
        else $error("flag cleared without write");

    cover property ($rose(timer_flag));
    cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
    cover property (s_axi_rvalid && s_axi_rready);
endmodule // sbit_chk

bind sbit_timer sbit_chk chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timer_flag(timer_flag));

// ### verification/sbit_pulse_src.sv
`timescale 1ns/1ps
module sbit_pulse_src
(
    // clock
    input  wire logic        aclk,
    // request
    input  wire logic        start,
    input  wire logic [15:0] count,
    input  wire logic [15:0] half,
    // pin side
    output logic             pin,
    output logic             busy
);
    int left = 0;
    int tick = 0;

    initial
    begin
        pin = 1'b0;
        busy = 1'b0;
    end

    // pin rests low between bursts, rising edge opens each pulse
    always @(posedge aclk)
    begin
        if (start && !busy)
        begin
            busy <= (count != 16'h0000);
            left <= count;
            tick <= 0;
        end
        else if (busy)
        begin
            pin <= (tick < half);
            tick <= (tick == 2 * half - 1) ? 0 : tick + 1;
            if (tick == 2 * half - 1)
            begin
                left <= left - 1;
                busy <= (left > 1);
            end
        end
    end
endmodule // sbit_pulse_src

// ### verification/tb_sixteen_bit_interval_timer.sv
`timescale 1ns/1ps
module tb_sixteen_bit_interval_timer;
    localparam logic [15:0] c_run  = 16'h0001 << sbit_pkg::run_bit;
    localparam logic [15:0] c_idle = 16'h0001 << sbit_pkg::idle_halt_bit;
    localparam logic [15:0] c_gate = 16'h0001 << sbit_pkg::gate_bit;
    localparam logic [15:0] c_sync = 16'h0001 << sbit_pkg::sync_bit;
    localparam logic [15:0] c_src  = 16'h0001 << sbit_pkg::source_bit;
    localparam logic [1:0]  ok     = sbit_pkg::resp_okay;
    localparam logic [1:0]  se     = sbit_pkg::resp_slverr;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  awaddr = 4'h0;
    logic [3:0]  araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h3;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        idle_mode = 1'b0;
    logic        ps_start = 1'b0;
    logic [15:0] ps_count = 16'h0;
    logic [15:0] ps_half = 16'h2;
    logic        pin, busy, flag, awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [31:0] seed = 32'hd11130ea;
    logic [15:0] ctl;
    int          failures = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          exp_cnt;
    int          div [4] = '{1, 8, 64, 256};

    sbit_timer dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .external_count_input(pin),
        .idle_mode(idle_mode), .timer_flag(flag));
    sbit_pulse_src src_u (.aclk(aclk), .start(ps_start), .count(ps_count), .half(ps_half), .pin(pin),
        .busy(busy));

    initial
    begin
        forever #10 aclk = ~aclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic conclude();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic tally(input logic bad);
        check_count = check_count + 1;
        if (bad)
        begin
            failures = failures + 1;
            $display("[ERR] %0t result differs from model", $time);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        // bready stays up between writes so a following call never re-raises it in the same step
        end while (bvalid !== 1'b1);
        tally(bresp !== er);
    endtask

    // tolerance lets free-running timer reads land within a small window
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [1:0] er, input int tol);
        int g;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        g = rdata[15:0];
        tally($isunknown({rresp, rdata}) || rresp !== er || rdata[31:16] !== 16'h0000 || g > e + tol || g + tol < e);
    endtask

    task automatic pulse(input int n, input int h);
        int k;
        k = 0;
        ps_count <= n[15:0];
        ps_half <= h[15:0];
        ps_start <= 1'b1;
        @(posedge aclk);
        ps_start <= 1'b0;
        @(posedge aclk);
        while (busy && k < 20000)
        begin
            @(posedge aclk);
            k = k + 1;
        end
        // pin synchronisers, edge flop, retime and prescaler settle
        repeat (8) @(posedge aclk);
    endtask

    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            failures = failures + 1;
            conclude();
        end
    end

    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(sbit_pkg::off_control, sbit_pkg::control_reset, ok, 0);
        rd(sbit_pkg::off_count, sbit_pkg::count_reset, ok, 0);
        rd(sbit_pkg::off_period, sbit_pkg::period_reset, ok, 0);
        rd(sbit_pkg::off_status, 16'h0000, ok, 0);
        rd(4'h2, 16'h0000, se, 0);
        wr(4'h2, 16'hffff, se);
        wr(sbit_pkg::off_control, ~sbit_pkg::control_mask, ok);
        rd(sbit_pkg::off_control, 16'h0000, ok, 0);
        for (int m = 0; m < 8; m++)
        begin
            seed = xs(seed);
            exp_cnt = 1 + seed[1:0] % 3;
            ctl = c_run | c_src | c_gate | (m[2] ? c_sync : 16'h0000) | (16'(m % 4) << sbit_pkg::prescale_lo);
            wr(sbit_pkg::off_count, 16'h0000, ok);
            wr(sbit_pkg::off_control, ctl, ok);
            pulse(exp_cnt * div[m % 4], 2);
            wr(sbit_pkg::off_control, 16'h0000, ok);
            rd(sbit_pkg::off_count, exp_cnt[15:0], ok, 0);
        end
        seed = xs(seed);
        wr(sbit_pkg::off_control, c_run | c_src | c_sync, ok);
        wr(sbit_pkg::off_count, seed[15:0], ok);
        rd(sbit_pkg::off_count, exp_cnt[15:0], ok, 0);
        wr(sbit_pkg::off_control, c_run | c_src, ok);
        wr(sbit_pkg::off_count, seed[15:0], ok);
        rd(sbit_pkg::off_count, seed[15:0], ok, 0);
        wr(sbit_pkg::off_control, 16'h0000, ok);
        wr(sbit_pkg::off_count, 16'h0000, ok);
        wr(sbit_pkg::off_period, 16'h0003, ok);
        wr(sbit_pkg::off_control, c_run | c_src | c_sync, ok);
        pulse(4, 2);
        rd(sbit_pkg::off_count, 16'h0000, ok, 0);
        tally(flag !== 1'b1);
        rd(sbit_pkg::off_status, 16'h0001, ok, 0);
        wr(sbit_pkg::off_status, 16'h0001, ok);
        rd(sbit_pkg::off_status, 16'h0000, ok, 0);
        wr(sbit_pkg::off_period, 16'hffff, ok);
        idle_mode <= 1'b1;
        wr(sbit_pkg::off_control, c_run | c_src | c_idle, ok);
        pulse(3, 2);
        rd(sbit_pkg::off_count, 16'h0000, ok, 0);
        rd(sbit_pkg::off_status, 16'h0002, ok, 0);
        wr(sbit_pkg::off_control, c_run | c_src, ok);
        pulse(3, 2);
        rd(sbit_pkg::off_count, 16'h0003, ok, 0);
        idle_mode <= 1'b0;
        wr(sbit_pkg::off_control, 16'h0000, ok);
        wr(sbit_pkg::off_count, 16'h0000, ok);
        wr(sbit_pkg::off_control, c_run | c_gate, ok);
        repeat (20) @(posedge aclk);
        seed = xs(seed);
        exp_cnt = 10 + seed[4:0];
        pulse(1, exp_cnt);
        wr(sbit_pkg::off_control, 16'h0000, ok);
        rd(sbit_pkg::off_count, exp_cnt[15:0], ok, 0);
        wr(sbit_pkg::off_count, 16'h0000, ok);
        wr(sbit_pkg::off_control, c_run | c_sync | 16'h0010, ok);
        repeat (800) @(posedge aclk);
        wr(sbit_pkg::off_control, 16'h0000, ok);
        rd(sbit_pkg::off_count, 16'h0064, ok, 2);
        conclude();
    end
endmodule // tb_sixteen_bit_interval_timer
